/* File: asc_adapter_model.sv */
// Behavioural adapter: converters, clock chip lock and serial slave.
`timescale 1ns/100ps
`default_nettype none
module asc_adapter_model (
  input wire logic mclk, // Clock.
  input wire logic [2:0] clockSource, // Source.
  input wire logic serialClk, // Serial clock.
  input wire logic serialData, // Serial data.
  input wire logic clockChipSelect_n, // Chip select.
  input wire logic converterSelect_n, // Converter select.
  output logic sampleClkPin, // Sample clock.
  output logic [3:0][15:0] converterData, // Samples.
  output logic lockPin, // Lock.
  output logic serialReturn, // Return data.
  output logic [15:0] lastFrame, // Last frame.
  output logic [7:0] chipFrames, // Chip frames.
  output logic [7:0] convFrames // Converter frames.
);
  logic [13:0] cnt = 14'h0;
  logic [15:0] sh = 16'h0;
  logic [2:0] srcQ = 3'h0;
  int bits = 0;
  int lockCnt = 0;
  logic toConv = 1'b0;
  logic idleBit = 1'b0;
  logic frameBit = 1'b0;
  localparam logic [7:0] REPLY = 8'hA5;
  // A released return line shows a toggling level, so stale data cannot pass for a reply.
  assign serialReturn = (clockChipSelect_n && converterSelect_n) ? idleBit : frameBit;
  initial begin
    sampleClkPin = 1'b0;
    lockPin = 1'b0;
    lastFrame = 16'h0;
    chipFrames = 8'h0;
    convFrames = 8'h0;
    #3;
    // An external source runs slower than the internal oscillator.
    forever #((clockSource == 3'h2 || clockSource == 3'h4) ? 60 : 40) sampleClkPin = !sampleClkPin;
  end
  always @(negedge sampleClkPin) cnt <= cnt + 14'h1;
  always_comb for (int c = 0; c < 4; c++) converterData[c] = {c[1:0], cnt};
  // Lock drops on a source change or while a frame is sent.
  always @(posedge mclk) begin
    srcQ <= clockSource;
    if (srcQ != clockSource || !(clockChipSelect_n && converterSelect_n)) lockCnt <= 0;
    else if (lockCnt < 100) lockCnt <= lockCnt + 1;
    lockPin <= lockCnt >= 100;
    if (clockChipSelect_n && converterSelect_n) idleBit <= !idleBit;
  end
  always @(negedge clockChipSelect_n or negedge converterSelect_n or posedge serialClk) begin
    if (!serialClk) begin
      bits = 0;
      toConv = !converterSelect_n;
    end else begin
      sh = {sh[14:0], serialData};
      bits = bits + 1;
    end
  end
  always @(negedge serialClk) if (bits >= 8 && bits < 16) frameBit <= REPLY[15 - bits];
  always @(posedge clockChipSelect_n or posedge converterSelect_n) begin
    if (bits == 16) begin
      lastFrame = sh;
      if (toConv) convFrames++;
      else chipFrames++;
    end
  end
endmodule
`default_nettype wire

/* File: asc_capture.sv */
// Four-channel converter capture interface with clock selection and serial programming engine.
`timescale 1ns/100ps
`default_nettype none

// Behaviour
// R01: In multi-sample mode two samples per channel appear per output clock, which runs at half the sample rate.
// R02: With no external clock the sample rate is 250 MHz and the multi-sample output clock is 125 MHz.
// R03: In single-sample mode exactly one sample per channel appears per output clock at the sample rate.
// R04: A slower sample rate comes only from an external clock source, and sample timing then follows that clock.
// R05: Both modes expose four analogue channels and eight programmable function lines.
// R06: The clock source selector has five settings covering internal, locked and external sources.
// R07: A programming engine configures the clock chip and converters from presets or raw address and data.
// R08: Without an explicit choice the interface starts in multi-sample mode.
// R09: The sample clock must lie between 175 MHz and 250 MHz from one of the three sources.
// R10: With the backplane sync clock as external source the converters are clocked directly from it.
// R11: The acquisition logic outside captures a record per software or data-edge trigger.
// R12: In multi-sample mode each channel shows the newer sample and the one just before it.
// R13: After a source change or reprogramming the outputs stay invalid until the new clock is locked and stable.
module asc_capture (
  input wire logic mclk, // System clock.
  input wire logic nrst, // Asynchronous active-low reset.
  input wire logic [3:0] regAddr, // Register byte address.
  input wire logic [31:0] regWdata, // Register write data.
  input wire logic regWr, // Write strobe.
  input wire logic regRd, // Read strobe.
  output logic [31:0] regRdata, // Read data, one cycle after the strobe.
  input wire logic sampleClkPin, // Sample clock from the adapter.
  input wire logic [3:0][15:0] converterData, // Converter outputs per channel.
  input wire logic lockPin, // Clock chip lock indicator.
  output logic [2:0] clockSource, // Source select to the clock chip.
  output logic syncDirect, // Converters clocked straight from the sync line.
  output logic serialClk, // Serial clock.
  output logic serialData, // Serial data out.
  input wire logic serialReturn, // Serial data in.
  output logic clockChipSelect_n, // Clock chip select.
  output logic converterSelect_n, // Converter select.
  input wire logic [7:0] funcLineIn, // Function line pin levels.
  output logic [7:0] funcLineOut, // Function line drive values.
  output logic [7:0] funcLineOe, // Function line drive enables.
  output logic outClk, // Output clock to user logic.
  output logic sampleValid, // Samples on the outputs are new.
  output logic [3:0][15:0] channelNewerSample, // Newest sample per channel.
  output logic [3:0][15:0] channelOlderSample // Preceding sample per channel.
);
  typedef enum logic [3:0] {
    SER_IDLE = 4'b0001,
    SER_LOAD = 4'b0010,
    SER_SHIFT = 4'b0100,
    SER_NEXT = 4'b1000
  } asc_ser_e;

  localparam logic [10:0] RATE_WIN_LAST = 11'(asc_pkg::RATE_WINDOW - 1);
  localparam logic [11:0] RATE_LO = 12'(asc_pkg::RATE_MIN_EDGES);
  localparam logic [11:0] RATE_HI = 12'(asc_pkg::RATE_MAX_EDGES);
  localparam logic [10:0] SETTLE_LAST = 11'(asc_pkg::SETTLE_CYCLES - 1);
  localparam logic [3:0] SCLK_LAST = 4'(asc_pkg::SCLK_HALF_CYCLES - 1);
  localparam logic [4:0] FRAME_LAST = 5'(asc_pkg::SER_FRAME_BITS - 1);
  localparam logic [1:0] PRESET_LAST = 2'(asc_pkg::PRESET_WORDS - 1);

  // Preset programming words for the clock chip, chosen by source and step.
  function automatic logic [15:0] presetWord(input logic [2:0] src, input logic [1:0] step);
    logic [15:0] w;
    w = {6'h00, step, 5'h00, src};
    case (step)
      2'h0: w = {8'h10, 5'h00, src};
      2'h1: w = {8'h11, 7'h00, (src == 3'(asc_pkg::SRC_LOCK_CLKIN)) || (src == 3'(asc_pkg::SRC_LOCK_SYNC))};
      2'h2: w = {8'h12, 7'h00, (src == 3'(asc_pkg::SRC_EXT_CLKIN)) || (src == 3'(asc_pkg::SRC_EXT_SYNC))};
      default: w = {8'h13, 8'h01};
    endcase
    return w;
  endfunction

  function automatic logic isWrite(input logic wr, input logic [3:0] addr, input logic [3:0] off);
    return wr && (addr == off);
  endfunction

  // Reset release.
  logic rstMeta, rstSync;
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      rstMeta <= 1'b0;
      rstSync <= 1'b0;
    end else begin
      rstMeta <= 1'b1;
      rstSync <= rstMeta;
    end
  end

  // Pin synchronisers.
  logic sclkMeta, sclkSync, sclkLast;
  logic lockMeta, lockSync, retMeta, retSync;
  logic [3:0][15:0] dataMeta, dataSync;
  logic [7:0] funcMeta, funcSync;
  always_ff @(posedge mclk or negedge rstSync) begin
    if (!rstSync) begin
      sclkMeta <= 1'b0;
      sclkSync <= 1'b0;
      sclkLast <= 1'b0;
      lockMeta <= 1'b0;
      lockSync <= 1'b0;
      retMeta <= 1'b0;
      retSync <= 1'b0;
      dataMeta <= '0;
      dataSync <= '0;
      funcMeta <= 8'h00;
      funcSync <= 8'h00;
    end else begin
      sclkMeta <= sampleClkPin;
      sclkSync <= sclkMeta;
      sclkLast <= sclkSync;
      lockMeta <= lockPin;
      lockSync <= lockMeta;
      retMeta <= serialReturn;
      retSync <= retMeta;
      dataMeta <= converterData;
      dataSync <= dataMeta;
      funcMeta <= funcLineIn;
      funcSync <= funcMeta;
    end
  end

  // Every sample follows the selected clock, whichever source feeds it.
  logic sampleEdge;
  assign sampleEdge = sclkSync && !sclkLast; // [R04]

  // Control register.
  logic multiMode;
  logic [2:0] srcSel;
  logic srcChange;
  assign srcChange = isWrite(regWr, regAddr, asc_pkg::OFF_CONTROL)
      && (regWdata[asc_pkg::CTRL_SRC_LSB +: 3] != srcSel);
  always_ff @(posedge mclk or negedge rstSync) begin
    if (!rstSync) begin
      multiMode <= asc_pkg::CTRL_MULTI_RESET; // [R08]
      srcSel <= asc_pkg::CTRL_SRC_RESET;
    end else if (isWrite(regWr, regAddr, asc_pkg::OFF_CONTROL)) begin
      multiMode <= regWdata[asc_pkg::CTRL_MULTI_BIT];
      if (regWdata[asc_pkg::CTRL_SRC_LSB +: 3] <= 3'(asc_pkg::SRC_EXT_SYNC)) begin
        srcSel <= regWdata[asc_pkg::CTRL_SRC_LSB +: 3]; // [R06]
      end
    end
  end
  assign clockSource = srcSel; // [R06]
  assign syncDirect = (srcSel == 3'(asc_pkg::SRC_EXT_SYNC)); // [R10]

  // Function lines.
  logic [7:0] funcOut, funcDir;
  always_ff @(posedge mclk or negedge rstSync) begin
    if (!rstSync) begin
      funcOut <= 8'h00;
      funcDir <= 8'h00;
    end else if (isWrite(regWr, regAddr, asc_pkg::OFF_FUNC)) begin
      funcOut <= regWdata[7:0]; // [R05]
      funcDir <= regWdata[asc_pkg::FUNC_DIR_LSB +: 8];
    end
  end
  assign funcLineOut = funcOut;
  assign funcLineOe = funcDir;

  // Serial programming engine.
  asc_ser_e serState;
  logic [15:0] shiftReg;
  logic [4:0] bitCnt;
  logic [3:0] divCnt;
  logic [1:0] presetStep;
  logic presetRun, toConverter, serDone;
  logic [7:0] readBack;
  logic cmdWrite;
  assign cmdWrite = isWrite(regWr, regAddr, asc_pkg::OFF_SERIAL) && (serState == SER_IDLE);
  always_ff @(posedge mclk or negedge rstSync) begin
    if (!rstSync) begin
      serState <= SER_IDLE;
      shiftReg <= 16'h0000;
      bitCnt <= 5'h00;
      divCnt <= 4'h0;
      presetStep <= 2'h0;
      presetRun <= 1'b0;
      toConverter <= 1'b0;
      serialClk <= 1'b0;
      clockChipSelect_n <= 1'b1;
      converterSelect_n <= 1'b1;
      readBack <= 8'h00;
      serDone <= 1'b0;
    end else begin
      serDone <= 1'b0;
      case (serState)
        SER_IDLE: begin
          if (cmdWrite) begin
            presetRun <= regWdata[asc_pkg::SER_PRESET_BIT]; // [R07]
            toConverter <= regWdata[asc_pkg::SER_TARGET_BIT] && !regWdata[asc_pkg::SER_PRESET_BIT];
            shiftReg <= regWdata[asc_pkg::SER_PRESET_BIT] ? presetWord(srcSel, 2'h0) : regWdata[15:0]; // [R07]
            presetStep <= 2'h0;
            serState <= SER_LOAD;
          end
        end
        SER_LOAD: begin
          clockChipSelect_n <= toConverter;
          converterSelect_n <= !toConverter;
          bitCnt <= 5'h00;
          divCnt <= 4'h0;
          serialClk <= 1'b0;
          serState <= SER_SHIFT;
        end
        SER_SHIFT: begin
          if (divCnt == SCLK_LAST) begin
            divCnt <= 4'h0;
            serialClk <= !serialClk;
            if (serialClk) begin
              shiftReg <= {shiftReg[14:0], 1'b0};
              if (bitCnt == FRAME_LAST) begin
                serState <= SER_NEXT;
              end
              bitCnt <= bitCnt + 5'h01;
            end else if (bitCnt >= 5'h08) begin
              readBack <= {readBack[6:0], retSync};
            end
          end else begin
            divCnt <= divCnt + 4'h1;
          end
        end
        SER_NEXT: begin
          clockChipSelect_n <= 1'b1;
          converterSelect_n <= 1'b1;
          if (presetRun && (presetStep != PRESET_LAST)) begin
            presetStep <= presetStep + 2'h1;
            shiftReg <= presetWord(srcSel, presetStep + 2'h1); // [R07]
            serState <= SER_LOAD;
          end else begin
            serDone <= 1'b1;
            serState <= SER_IDLE;
          end
        end
        default: serState <= SER_IDLE;
      endcase
    end
  end
  assign serialData = shiftReg[15];

  // Sample clock rate window check.
  logic [10:0] winCnt;
  logic [11:0] edgeCnt;
  logic rateOk;
  always_ff @(posedge mclk or negedge rstSync) begin
    if (!rstSync) begin
      winCnt <= 11'h000;
      edgeCnt <= 12'h000;
      rateOk <= 1'b0;
    end else begin
      if (winCnt == RATE_WIN_LAST) begin
        winCnt <= 11'h000;
        edgeCnt <= 12'(sampleEdge);
        rateOk <= (edgeCnt >= RATE_LO) && (edgeCnt <= RATE_HI); // [R09]
      end else begin
        winCnt <= winCnt + 11'h001;
        edgeCnt <= edgeCnt + 12'(sampleEdge);
      end
    end
  end

  // Lock settling.
  logic [10:0] settleCnt;
  logic stable;
  always_ff @(posedge mclk or negedge rstSync) begin
    if (!rstSync) begin
      settleCnt <= 11'h000;
      stable <= 1'b0;
    end else if (srcChange || (serState != SER_IDLE) || serDone || !lockSync) begin
      settleCnt <= 11'h000; // [R13]
      stable <= 1'b0;
    end else if (!stable) begin
      if (settleCnt == SETTLE_LAST) begin
        stable <= 1'b1; // [R13]
      end else begin
        settleCnt <= settleCnt + 11'h001;
      end
    end
  end

  // Sample delivery.
  // The pair phase toggles on each sample edge; single-sample mode keeps it cleared.
  logic phase;
  always_ff @(posedge mclk or negedge rstSync) begin
    if (!rstSync) begin
      phase <= 1'b0;
    end else if (!multiMode) begin
      phase <= 1'b0;
    end else if (sampleEdge) begin
      phase <= !phase;
    end
  end

  // In multi-sample mode the output clock toggles once per sample edge, so it runs at half the sample rate.
  always_ff @(posedge mclk or negedge rstSync) begin
    if (!rstSync) begin
      outClk <= 1'b0;
    end else if (!multiMode) begin
      outClk <= sclkSync; // [R03]
    end else if (sampleEdge) begin
      outClk <= !phase; // [R01] [R02]
    end
  end

  // Valid is a one-cycle pulse, raised only once the clock has settled.
  always_ff @(posedge mclk or negedge rstSync) begin
    if (!rstSync) begin
      sampleValid <= 1'b0;
    end else if (!sampleEdge) begin
      sampleValid <= 1'b0;
    end else if (multiMode) begin
      sampleValid <= phase && stable; // [R01] [R13]
    end else begin
      sampleValid <= stable; // [R03] [R13]
    end
  end

  // Both sample registers move on every edge, so the older one always holds the sample just before.
  always_ff @(posedge mclk or negedge rstSync) begin
    if (!rstSync) begin
      channelNewerSample <= '0;
      channelOlderSample <= '0;
    end else if (sampleEdge) begin
      channelNewerSample <= dataSync; // [R05]
      channelOlderSample <= channelNewerSample; // [R12]
    end
  end

  // Register reads.
  always_ff @(posedge mclk or negedge rstSync) begin
    if (!rstSync) begin
      regRdata <= 32'h0000_0000;
    end else if (regRd) begin
      case (regAddr)
        asc_pkg::OFF_CONTROL: regRdata <= {28'h0000000, srcSel, multiMode};
        asc_pkg::OFF_STATUS: regRdata <= {16'h0000, readBack, 4'h0, rateOk, stable, lockSync,
                                          serState != SER_IDLE};
        asc_pkg::OFF_FUNC: regRdata <= {8'h00, funcSync, funcDir, funcOut}; // [R05]
        default: regRdata <= 32'h0000_0000;
      endcase
    end else begin
      regRdata <= 32'h0000_0000;
    end
  end
endmodule

`default_nettype wire

/* File: asc_capture_checker.sv */
// Port assertions for the capture interface.
`timescale 1ns/100ps
`default_nettype none
module asc_capture_checker (
  input wire logic mclk, // Clock.
  input wire logic nrst, // Reset.
  input wire logic [3:0] regAddr, // Address.
  input wire logic [31:0] regWdata, // Write data.
  input wire logic regWr, // Write strobe.
  input wire logic [2:0] clockSource, // Source.
  input wire logic syncDirect, // Direct sync.
  input wire logic serialClk, // Serial clock.
  input wire logic clockChipSelect_n, // Chip select.
  input wire logic converterSelect_n, // Converter select.
  input wire logic sampleValid, // Valid.
  input wire logic [3:0][15:0] channelNewerSample, // Newer.
  input wire logic [3:0][15:0] channelOlderSample // Older.
);
  localparam int SETTLE = asc_pkg::SETTLE_CYCLES - 2;
  logic idle;
  logic ctlWr;
  int quiet;
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);
  assign idle = clockChipSelect_n && converterSelect_n;
  assign ctlWr = regWr && regAddr == asc_pkg::OFF_CONTROL;
  // Counts cycles since the last source change or serial frame.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) quiet <= 0;
    else if ($changed(clockSource) || !idle) quiet <= 0;
    else if (quiet < 4000) quiet <= quiet + 1;
  end
  sequence s_idle;
    idle [*4];
  endsequence
  sequence s_serial_go;
    regWr && regAddr == asc_pkg::OFF_SERIAL;
  endsequence
  a_sync_direct_map: assert property (syncDirect == (clockSource == 3'h4))
    else $error("sync line select wrong");
  a_source_taken: assert property (ctlWr && regWdata[3:1] <= 3'h4 |=> clockSource == $past(regWdata[3:1]))
    else $error("source not taken");
  a_source_refused: assert property (ctlWr && regWdata[3:1] > 3'h4 |=> $stable(clockSource))
    else $error("bad source taken");
  a_valid_pulse: assert property (sampleValid |=> !sampleValid)
    else $error("valid longer than one cycle");
  a_valid_settled: assert property (sampleValid |-> quiet >= SETTLE)
    else $error("valid before settling");
  a_older_follows: assert property ($changed(channelNewerSample) |-> channelOlderSample == $past(channelNewerSample))
    else $error("older sample not previous");
  a_valid_fresh: assert property (sampleValid |-> $changed(channelNewerSample))
    else $error("valid without new sample");
  a_serial_start: assert property (s_idle ##0 s_serial_go |-> ##2 !idle)
    else $error("frame did not start");
  a_sclk_high: assert property ($rose(serialClk) |-> serialClk [*5] ##1 !serialClk)
    else $error("serial clock high phase wrong");
endmodule
bind asc_capture asc_capture_checker asc_capture_checker_inst (.mclk, .nrst, .regAddr, .regWdata, .regWr, .clockSource,
  .syncDirect, .serialClk, .clockChipSelect_n, .converterSelect_n, .sampleValid, .channelNewerSample, .channelOlderSample);
`default_nettype wire

/* File: asc_pkg.sv */
// Constants shared by the sample capture interface.
package asc_pkg;
  localparam int CHANNELS = 4;
  localparam int SAMPLE_BITS = 16;
  localparam int FUNC_LINES = 8;
  // Register byte offsets.
  localparam logic [3:0] OFF_CONTROL = 4'h0;
  localparam logic [3:0] OFF_SERIAL = 4'h4;
  localparam logic [3:0] OFF_STATUS = 4'h8;
  localparam logic [3:0] OFF_FUNC = 4'hC;
  // Control register fields and reset values.
  localparam int CTRL_MULTI_BIT = 0;
  localparam int CTRL_SRC_LSB = 1;
  localparam logic CTRL_MULTI_RESET = 1'b1;
  localparam logic [2:0] CTRL_SRC_RESET = 3'h0;
  // Serial command fields.
  localparam int SER_TARGET_BIT = 31;
  localparam int SER_PRESET_BIT = 30;
  localparam int SER_ADDR_LSB = 8;
  localparam int SER_FRAME_BITS = 16;
  localparam int PRESET_WORDS = 4;
  // Status register fields.
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_LOCK_BIT = 1;
  localparam int STAT_STABLE_BIT = 2;
  localparam int STAT_RATE_BIT = 3;
  localparam int STAT_READ_LSB = 8;
  // Function line register fields.
  localparam int FUNC_DIR_LSB = 8;
  localparam int FUNC_IN_LSB = 16;
  // Clock source settings.
  typedef enum logic [2:0] {
    SRC_INTERNAL = 3'h0,
    SRC_LOCK_CLKIN = 3'h1,
    SRC_EXT_CLKIN = 3'h2,
    SRC_LOCK_SYNC = 3'h3,
    SRC_EXT_SYNC = 3'h4
  } asc_src_e;
  // Timing.
  localparam int MCLK_MHZ = 125;
  localparam int RATE_DEFAULT_MHZ = 250;
  localparam int OUT_CLK_DEFAULT_MHZ = 125;
  localparam int RATE_MIN_MHZ = 175;
  localparam int RATE_MAX_MHZ = 250;
  localparam int RATE_WINDOW = 1024;
  localparam int RATE_MIN_EDGES = RATE_MIN_MHZ * RATE_WINDOW / MCLK_MHZ;
  localparam int RATE_MAX_EDGES = (RATE_MAX_MHZ * RATE_WINDOW + MCLK_MHZ - 1) / MCLK_MHZ;
  localparam int SETTLE_US = 10;
  localparam int SETTLE_CYCLES = SETTLE_US * MCLK_MHZ;
  localparam int SCLK_HALF_NS = 40;
  localparam int SCLK_HALF_CYCLES = (SCLK_HALF_NS * MCLK_MHZ + 999) / 1000;
endpackage

/* File: tb_top.sv */
// Self-checking bench for the capture interface.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic mclk, nrst, regWr, regRd, sampleClkPin, lockPin, serialReturn, outClk, sampleValid, syncDirect;
  logic serialClk, serialData, clockChipSelect_n, converterSelect_n;
  logic [3:0] regAddr;
  logic [31:0] regWdata, regRdata, rd;
  logic [2:0] clockSource;
  logic [3:0][15:0] converterData, channelNewerSample, channelOlderSample;
  logic [7:0] funcLineIn, funcLineOut, funcLineOe, chipFrames, convFrames;
  logic [15:0] lastFrame;
  int mismatches = 0;
  int n_tests = 0;
  int cyc = 0;
  asc_capture asc_capture_inst (.mclk, .nrst, .regAddr, .regWdata, .regWr, .regRd, .regRdata, .sampleClkPin,
    .converterData, .lockPin, .clockSource, .syncDirect, .serialClk, .serialData, .serialReturn, .clockChipSelect_n,
    .converterSelect_n, .funcLineIn, .funcLineOut, .funcLineOe, .outClk, .sampleValid, .channelNewerSample,
    .channelOlderSample);
  asc_adapter_model asc_adapter_model_inst (.mclk, .clockSource, .serialClk, .serialData, .clockChipSelect_n,
    .converterSelect_n, .sampleClkPin, .converterData, .lockPin, .serialReturn, .lastFrame, .chipFrames, .convFrames);
  initial begin
    mclk = 1'b0;
    forever #4 mclk = !mclk;
  end
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      mismatches++;
      test_done();
    end
  end
  task automatic test_done();
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge mclk);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge mclk);
    regWr <= 1'b0;
  endtask
  task automatic rdr(input logic [3:0] a);
    @(posedge mclk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge mclk);
    regRd <= 1'b0;
    @(negedge mclk);
    rd = regRdata;
  endtask
  task automatic wait_stat(input int b, input logic v);
    rdr(asc_pkg::OFF_STATUS);
    for (int i = 0; i < 1000 && rd[b] !== v; i++) rdr(asc_pkg::OFF_STATUS);
  endtask
  // Counts valid pulses and output clock rises over a window.
  task automatic count(input int len, output int nv, output int nc);
    logic p;
    nv = 0;
    nc = 0;
    p = outClk;
    repeat (len) begin
      @(negedge mclk);
      nv += int'(sampleValid === 1'b1);
      nc += int'(outClk === 1'b1 && p === 1'b0);
      p = outClk;
    end
  endtask
  task automatic t_reset();
    rdr(asc_pkg::OFF_CONTROL);
    check(rd[3:0], 4'h1);
    rdr(4'h2);
    check(rd, 32'h0);
    $display("reset test done");
  endtask
  task automatic t_multi();
    int nv, nc;
    logic [13:0] prev;
    wait_stat(asc_pkg::STAT_STABLE_BIT, 1'b1);
    check(rd[asc_pkg::STAT_LOCK_BIT], 1'b1);
    check(rd[asc_pkg::STAT_RATE_BIT], 1'b0);
    count(200, nv, nc);
    check(nv, 10);
    check(nc, 10);
    for (int i = 0; i < 40 && sampleValid !== 1'b1; i++) @(negedge mclk);
    for (int c = 0; c < 4; c++) begin
      check(channelNewerSample[c][15:14], c[1:0]);
      check(14'(channelNewerSample[c][13:0] - channelOlderSample[c][13:0]), 14'h1);
    end
    // Four successive valid pulses each bring a new sample pair, two samples on from the last.
    for (int k = 0; k < 4; k++) begin
      prev = channelNewerSample[0][13:0];
      @(negedge mclk);
      for (int i = 0; i < 40 && sampleValid !== 1'b1; i++) @(negedge mclk);
      check(14'(channelNewerSample[0][13:0] - prev), 14'h2);
    end
    $display("multi test done");
  endtask
  task automatic t_single();
    int nv, nc;
    wr(asc_pkg::OFF_CONTROL, 32'h0);
    wait_stat(asc_pkg::STAT_STABLE_BIT, 1'b1);
    count(200, nv, nc);
    check(nv, 20);
    check(nc, 20);
    wr(asc_pkg::OFF_CONTROL, 32'h1);
    $display("single test done");
  endtask
  task automatic t_source();
    int nv, nc;
    for (int s = 1; s < 6; s++) begin
      wr(asc_pkg::OFF_CONTROL, 32'(s * 2 + 1));
      @(negedge mclk);
      check(clockSource, (s > 4) ? 3'h4 : 3'(s));
      check(syncDirect, 1'(s >= 4));
      count(1200, nv, nc);
      check(nv, 0);
    end
    wait_stat(asc_pkg::STAT_STABLE_BIT, 1'b1);
    count(300, nv, nc);
    check(nv, 10);
    $display("source test done");
  endtask
  task automatic t_serial();
    logic [7:0] c0, h0;
    c0 = convFrames;
    h0 = chipFrames;
    wr(asc_pkg::OFF_SERIAL, 32'h80001234);
    repeat (3) @(posedge mclk);
    wr(asc_pkg::OFF_SERIAL, 32'h00005678);
    wait_stat(asc_pkg::STAT_BUSY_BIT, 1'b0);
    check(lastFrame, 16'h1234);
    check(convFrames, c0 + 8'h1);
    check(chipFrames, h0);
    check(rd[15:8], 8'hA5);
    wr(asc_pkg::OFF_SERIAL, 32'h40000000);
    wait_stat(asc_pkg::STAT_BUSY_BIT, 1'b0);
    check(chipFrames, h0 + 8'h4);
    wr(asc_pkg::OFF_SERIAL, 32'h00005678);
    wait_stat(asc_pkg::STAT_BUSY_BIT, 1'b0);
    check(lastFrame, 16'h5678);
    check(chipFrames, h0 + 8'h5);
    $display("serial test done");
  endtask
  task automatic t_func();
    @(posedge mclk);
    funcLineIn <= 8'h3C;
    wr(asc_pkg::OFF_FUNC, 32'h0000F05A);
    repeat (4) @(posedge mclk);
    rdr(asc_pkg::OFF_FUNC);
    check(funcLineOut, 8'h5A);
    check(funcLineOe, 8'hF0);
    check(rd[23:16], 8'h3C);
    $display("function line test done");
  endtask
  initial begin
    nrst = 1'b0;
    regWr = 1'b0;
    regRd = 1'b0;
    regAddr = 4'h0;
    regWdata = 32'h0;
    funcLineIn = 8'h00;
    repeat (16) @(posedge mclk);
    nrst <= 1'b1;
    repeat (3) @(posedge mclk);
    t_reset();
    t_multi();
    t_single();
    t_source();
    t_serial();
    t_func();
    test_done();
  end
endmodule
`default_nettype wire
